// [hdl/dmp_fifo.sv]
// Module: small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an active-low asynchronous reset.
`default_nettype none
module dmp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign in_ready = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end
      else
      begin
         if (push)
            wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + AW'(1);
         if (pop)
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + AW'(1);
         if (push && !pop)
            count <= count + (AW+1)'(1);
         else if (pop && !push)
            count <= count - (AW+1)'(1);
      end
   end
   always_ff @(posedge clk)
   begin
      if (push)
         mem[wr_ptr] <= in_data;
   end
endmodule // dmp_fifo
`default_nettype wire

// [hdl/dmp_parser.sv]
// Module: command parser of a dot-matrix printer fed by a parallel host port.
// Assumes host data/strobe/init/select pins are asynchronous; one 125 MHz clock.
// Notes on behaviour
// RULE_01: SO sets double width; CR, LF, DC4 clear
// RULE_02: SI sets compressed; DC2 clears it
// RULE_03: DC1/DC3 select/deselect unless override switch; DC3 needs select_input low, and no byte is taken while deselected
// RULE_04: CAN clears buffer, drops only double width
// RULE_05: ESC makes next byte a command selector
// RULE_06: ESC minus n sets underline on/off
// RULE_07: ESC 0 eighth inch, ESC 1 seven/72
// RULE_08: ESC 2 applies pending pitch, else sixth
// RULE_09: ESC A n stores pending n/72 pitch
// RULE_10: ESC 3 n sets pitch n/216 now
// RULE_11: ESC 6/7 picks charset; set 1 default
// RULE_12: ESC 8 ignores paper end; ESC 9 restores
// RULE_13: ESC less-than homes head for one line
// RULE_14: ESC B collects vertical tabs till NUL
// RULE_15: VT acts as LF without stops
// RULE_16: ESC C n sets page length, default 66
// RULE_17: ESC D stores ascending horizontal tab columns
// RULE_18: ESC E emphasized half speed; ESC F off
// RULE_19: ESC G double strike, ESC H off
// RULE_20: ESC J n gives one n/216 feed
// RULE_21: ESC K count bytes then graphics data
// RULE_22: Graphics byte is eight dots, text six; line_dots adds 1 per graphics byte and 6 per character
// RULE_23: Unknown selector dropped, state kept
// RULE_24: Host waits for accept pulse or busy
// RULE_25: Init low resets parser and buffer
// RULE_26: CR prints line; LF feeds one pitch
`default_nettype none
module dmp_parser
   import dmp_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] host_data,
   input wire logic host_strobe_n,
   input wire logic init_n,
   input wire logic select_input,
   input wire logic select_override_switch,
   input wire logic paper_end_sensor,
   output logic busy,
   output logic byte_accept_pulse,
   output logic selected,
   output logic paper_end,
   output logic mode_double_width,
   output logic mode_compressed,
   output logic mode_underline,
   output logic mode_emphasized,
   output logic mode_half_speed,
   output logic mode_double_strike,
   output logic [8:0] dstrike_step,
   output logic mode_charset_2,
   output logic [8:0] line_pitch,
   output logic [6:0] page_length,
   output logic home_head_pending,
   output logic [6:0] vtab_count,
   output logic [6:0] htab_count,
   output logic [7:0] tab_stop_value,
   output logic vtab_stop_write,
   output logic htab_stop_write,
   output logic buffer_clear,
   output logic print_line,
   output logic feed_pulse,
   output logic [8:0] feed_amount,
   output logic char_valid,
   output logic [7:0] char_data,
   output logic gfx_valid,
   output logic [7:0] gfx_data,
   output logic [9:0] line_dots
);
   logic rst_s1, rst_s2;
   logic [2:0] strobe_sync, init_sync, sel_sync;
   logic strobe_q, init_q, sel_q;
   logic [7:0] data_q;
   logic init_low, core_rst_n;
   int unsigned init_cnt;
   dmp_state_t state;
   logic [7:0] cmd;
   logic [9:0] gfx_left;
   logic [8:0] pending_pitch;
   logic pending_valid;
   logic [7:0] last_tab;
   logic [6:0] list_cnt;
   logic accepting, ignore_pe;
   // Reset release through two flops
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
         {rst_s2, rst_s1} <= 2'h0;
      else
         {rst_s2, rst_s1} <= {rst_s1, 1'b1};
   wire srst_n = rst_s2;
   // Strobe, init and select pins: three flops, change taken when stages two and three agree; host data one flop
   always_ff @(posedge clk or negedge srst_n)
   begin
      if (!srst_n)
      begin
         {strobe_sync, init_sync, sel_sync} <= 9'h1F8;
         {strobe_q, init_q, sel_q} <= 3'h6;
         data_q <= 8'h00;
      end
      else
      begin
         strobe_sync <= {strobe_sync[1:0], host_strobe_n};
         init_sync <= {init_sync[1:0], init_n};
         sel_sync <= {sel_sync[1:0], select_input};
         if (strobe_sync[1] == strobe_sync[2])
            strobe_q <= strobe_sync[2];
         if (init_sync[1] == init_sync[2])
            init_q <= init_sync[2];
         if (sel_sync[1] == sel_sync[2])
            sel_q <= sel_sync[2];
         data_q <= host_data;
      end
   end
   // Host data is stable around the strobe; capture on the falling edge
   wire strobe_fall = strobe_q && (strobe_sync[1] == strobe_sync[2]) && !strobe_sync[2];
   // Init low held for the minimum width resets the parser and buffer
   always_ff @(posedge clk or negedge srst_n)
   begin
      if (!srst_n)
      begin
         init_cnt <= 0;
         init_low <= 1'b0;
         core_rst_n <= 1'b0;
      end
      else
      begin
         init_cnt <= init_q ? 0 : ((init_cnt < INIT_MIN_CYC) ? init_cnt + 1 : init_cnt);
         init_low <= !init_q && (init_cnt >= INIT_MIN_CYC - 1); // [RULE_25]
         core_rst_n <= !init_low;
      end
   end
   wire pr_rst = init_low;
   wire fifo_in_ready;
   wire fifo_valid;
   wire [7:0] fifo_byte;
   wire take_in = strobe_fall && (accepting || select_override_switch); // [RULE_03]
   assign busy = !fifo_in_ready || !(accepting || select_override_switch);
   dmp_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .rst_n(srst_n),
      .in_valid(take_in),
      .in_ready(fifo_in_ready),
      .in_data(data_q),
      .out_valid(fifo_valid),
      .out_ready(1'b1),
      .out_data(fifo_byte)
   );
   // Byte decode
   wire b_ok = fifo_valid && !pr_rst;
   wire in_data_st = (state == ST_DATA);
   wire is_lf = in_data_st && (fifo_byte == CODE_LF);
   wire is_vt = in_data_st && (fifo_byte == CODE_VT);
   wire is_cr = in_data_st && (fifo_byte == CODE_CR);
   wire is_ctrl = in_data_st && (fifo_byte < 8'h20);
   wire vt_as_lf = is_vt && (vtab_count == 7'h00); // [RULE_15]
   wire sel_known = (fifo_byte == SEL_UNDERLINE) || (fifo_byte == SEL_PITCH_72)
      || (fifo_byte == SEL_PITCH_216) || (fifo_byte == SEL_PAGE_LEN)
      || (fifo_byte == SEL_ONE_FEED);
   wire sel_list = (fifo_byte == SEL_VTABS) || (fifo_byte == SEL_HTABS);
   wire [8:0] param9 = {1'b0, fifo_byte};
   wire [8:0] param72 = 9'(param9 * PITCH_72_SCALE);
   wire [9:0] gfx_total = (fifo_byte > 8'h01) ? GFX_MAX_BYTES : {fifo_byte[1:0], cmd};
   wire [7:0] col_max = mode_compressed ? HTAB_COL_MAX_COMP : HTAB_COL_MAX;
   wire cancel_hit = b_ok && in_data_st && (fifo_byte == CODE_CANCEL);
   // Init pulse resets all parser state through core_rst_n
   always_ff @(posedge clk or negedge core_rst_n)
   begin
      if (!core_rst_n)
      begin
         state <= ST_DATA; // [RULE_25]
         cmd <= 8'h00;
         gfx_left <= 10'h000;
         accepting <= 1'b1;
         {mode_double_width, mode_compressed, mode_underline} <= 3'h0;
         {mode_emphasized, mode_double_strike, mode_charset_2} <= 3'h0; // [RULE_11]
         {paper_end, ignore_pe, pending_valid, home_head_pending} <= 4'h0; // [RULE_12]
         line_pitch <= PITCH_SIXTH;
         pending_pitch <= PITCH_SIXTH;
         page_length <= PAGE_LEN_DEFAULT; // [RULE_16]
         {vtab_count, htab_count, list_cnt} <= 21'h0_0000; // [RULE_14]
         {last_tab, tab_stop_value, char_data, gfx_data} <= 32'h0000_0000;
         {vtab_stop_write, htab_stop_write, print_line} <= 3'h0;
         {feed_pulse, char_valid, gfx_valid} <= 3'h0;
         feed_amount <= 9'h000;
         line_dots <= 10'h000;
      end
      else
      begin
         {vtab_stop_write, htab_stop_write, print_line} <= 3'h0;
         {feed_pulse, char_valid, gfx_valid} <= 3'h0;
         paper_end <= paper_end_sensor && !ignore_pe;
         if (b_ok)
         begin
            case (state)
               ST_DATA:
               begin
                  if (is_cr || is_lf || vt_as_lf)
                  begin
                     mode_double_width <= 1'b0; // [RULE_01]
                     print_line <= 1'b1; // [RULE_26]
                     line_dots <= 10'h000;
                     home_head_pending <= 1'b0; // [RULE_13]
                     if (!is_cr)
                     begin
                        feed_pulse <= 1'b1; // [RULE_26]
                        feed_amount <= line_pitch;
                     end
                  end
                  else if (fifo_byte == CODE_WIDE_ON)
                     mode_double_width <= 1'b1; // [RULE_01]
                  else if (fifo_byte == CODE_WIDE_OFF)
                     mode_double_width <= 1'b0; // [RULE_01]
                  else if (fifo_byte == CODE_COMP_ON)
                     mode_compressed <= 1'b1; // [RULE_02]
                  else if (fifo_byte == CODE_COMP_OFF)
                     mode_compressed <= 1'b0; // [RULE_02]
                  else if (fifo_byte == CODE_SEL_ON && !select_override_switch)
                     accepting <= 1'b1; // [RULE_03]
                  else if (fifo_byte == CODE_SEL_OFF && !select_override_switch && !sel_q)
                     accepting <= 1'b0; // [RULE_03]
                  else if (fifo_byte == CODE_CANCEL)
                  begin
                     mode_double_width <= 1'b0; // [RULE_04]
                     line_dots <= 10'h000;
                  end
                  else if (fifo_byte == CODE_ESC)
                     state <= ST_SELECT; // [RULE_05]
                  else if (!is_ctrl)
                  begin
                     char_valid <= 1'b1;
                     char_data <= fifo_byte;
                     line_dots <= line_dots + TEXT_DOTS; // [RULE_22]
                  end
               end
               ST_SELECT:
               begin
                  cmd <= fifo_byte;
                  state <= ST_DATA;
                  list_cnt <= 7'h00;
                  last_tab <= 8'h00;
                  case (fifo_byte)
                     SEL_PITCH_8TH: line_pitch <= PITCH_EIGHTH; // [RULE_07]
                     SEL_PITCH_7_72: line_pitch <= PITCH_7_72; // [RULE_07]
                     SEL_PITCH_APPLY: line_pitch <= pending_valid ? pending_pitch
                        : PITCH_SIXTH; // [RULE_08]
                     SEL_CHARSET_2: mode_charset_2 <= 1'b1; // [RULE_11]
                     SEL_CHARSET_1: mode_charset_2 <= 1'b0; // [RULE_11]
                     SEL_PE_IGNORE: ignore_pe <= 1'b1; // [RULE_12]
                     SEL_PE_SENSE: ignore_pe <= 1'b0; // [RULE_12]
                     SEL_HOME_HEAD: home_head_pending <= 1'b1; // [RULE_13]
                     SEL_EMPH_ON: mode_emphasized <= 1'b1; // [RULE_18]
                     SEL_EMPH_OFF: mode_emphasized <= 1'b0; // [RULE_18]
                     SEL_DSTRIKE_ON: mode_double_strike <= 1'b1; // [RULE_19]
                     SEL_DSTRIKE_OFF: mode_double_strike <= 1'b0; // [RULE_19]
                     SEL_GRAPHICS: state <= ST_GFX_LO; // [RULE_21]
                     default:
                        if (sel_known)
                           state <= ST_PARAM;
                        else if (sel_list)
                           state <= ST_LIST; // [RULE_14] [RULE_17]
                        else
                           state <= ST_DATA; // [RULE_23]
                  endcase
               end
               ST_PARAM:
               begin
                  state <= ST_DATA;
                  case (cmd)
                     SEL_UNDERLINE:
                        if (fifo_byte == 8'h01)
                           mode_underline <= 1'b1; // [RULE_06]
                        else if (fifo_byte == 8'h00)
                           mode_underline <= 1'b0; // [RULE_06]
                     SEL_PITCH_72:
                        if (fifo_byte != 8'h00 && fifo_byte <= PITCH_72_MAX)
                        begin
                           pending_pitch <= param72; // [RULE_09]
                           pending_valid <= 1'b1;
                        end
                     SEL_PITCH_216:
                        if (fifo_byte != 8'h00)
                           line_pitch <= param9; // [RULE_10]
                     SEL_PAGE_LEN:
                        if (fifo_byte != 8'h00)
                           page_length <= (fifo_byte > {1'b0, PAGE_LEN_MAX}) ? PAGE_LEN_MAX
                              : fifo_byte[6:0]; // [RULE_16]
                     SEL_ONE_FEED:
                        if (fifo_byte != 8'h00)
                        begin
                           feed_pulse <= 1'b1; // [RULE_20]
                           feed_amount <= param9;
                        end
                     default: state <= ST_DATA;
                  endcase
               end
               ST_LIST:
               begin
                  if (fifo_byte == CODE_NUL)
                  begin
                     state <= ST_DATA;
                     if (cmd == SEL_VTABS)
                        vtab_count <= list_cnt; // [RULE_14]
                     else
                        htab_count <= list_cnt; // [RULE_17]
                  end
                  else if (fifo_byte > last_tab)
                  begin
                     last_tab <= fifo_byte;
                     tab_stop_value <= fifo_byte;
                     if (cmd == SEL_VTABS && list_cnt < 7'(VTAB_MAX))
                     begin
                        vtab_stop_write <= 1'b1; // [RULE_14]
                        list_cnt <= list_cnt + 7'h01;
                     end
                     else if (cmd == SEL_HTABS && list_cnt < 7'(HTAB_MAX)
                        && fifo_byte <= col_max)
                     begin
                        htab_stop_write <= 1'b1; // [RULE_17]
                        list_cnt <= list_cnt + 7'h01;
                     end
                  end
               end
               ST_GFX_LO:
               begin
                  cmd <= fifo_byte;
                  state <= ST_GFX_HI;
               end
               ST_GFX_HI:
               begin
                  gfx_left <= (gfx_total > GFX_MAX_BYTES) ? GFX_MAX_BYTES : gfx_total; // [RULE_21]
                  state <= (gfx_total == 10'h000) ? ST_DATA : ST_GFX_DATA;
               end
               ST_GFX_DATA:
               begin
                  gfx_valid <= 1'b1; // [RULE_22]
                  gfx_data <= fifo_byte;
                  line_dots <= line_dots + 10'h001;
                  gfx_left <= gfx_left - 10'h001;
                  if (gfx_left == 10'h001)
                     state <= ST_DATA; // [RULE_21]
               end
               default: state <= ST_DATA;
            endcase
         end
      end
   end
   // One accept pulse per byte taken; buffer clear on cancel or init
   always_ff @(posedge clk or negedge srst_n)
   begin
      if (!srst_n)
      begin
         byte_accept_pulse <= 1'b0;
         buffer_clear <= 1'b0;
      end
      else
      begin
         byte_accept_pulse <= take_in; // [RULE_24]
         buffer_clear <= cancel_hit || init_low; // [RULE_04] [RULE_25]
      end
   end
   assign selected = accepting || select_override_switch;
   assign mode_half_speed = mode_emphasized; // [RULE_18]
   assign dstrike_step = mode_double_strike ? DSTRIKE_STEP : 9'h000; // [RULE_19]
endmodule // dmp_parser
`default_nettype wire

// [hdl/dmp_pkg.sv]
// Package: byte codes, defaults and widths for the print command parser.
// Assumes an 8-bit host data path and one 125 MHz clock.
`default_nettype none
package dmp_pkg;
   localparam logic [7:0] CODE_NUL = 8'h00;
   localparam logic [7:0] CODE_LF = 8'h0A;
   localparam logic [7:0] CODE_VT = 8'h0B;
   localparam logic [7:0] CODE_CR = 8'h0D;
   localparam logic [7:0] CODE_WIDE_ON = 8'h0E;
   localparam logic [7:0] CODE_COMP_ON = 8'h0F;
   localparam logic [7:0] CODE_SEL_ON = 8'h11;
   localparam logic [7:0] CODE_COMP_OFF = 8'h12;
   localparam logic [7:0] CODE_SEL_OFF = 8'h13;
   localparam logic [7:0] CODE_WIDE_OFF = 8'h14;
   localparam logic [7:0] CODE_CANCEL = 8'h18;
   localparam logic [7:0] CODE_ESC = 8'h1B;
   localparam logic [7:0] SEL_UNDERLINE = 8'h2D;
   localparam logic [7:0] SEL_PITCH_8TH = 8'h30;
   localparam logic [7:0] SEL_PITCH_7_72 = 8'h31;
   localparam logic [7:0] SEL_PITCH_APPLY = 8'h32;
   localparam logic [7:0] SEL_PITCH_216 = 8'h33;
   localparam logic [7:0] SEL_CHARSET_2 = 8'h36;
   localparam logic [7:0] SEL_CHARSET_1 = 8'h37;
   localparam logic [7:0] SEL_PE_IGNORE = 8'h38;
   localparam logic [7:0] SEL_PE_SENSE = 8'h39;
   localparam logic [7:0] SEL_HOME_HEAD = 8'h3C;
   localparam logic [7:0] SEL_PITCH_72 = 8'h41;
   localparam logic [7:0] SEL_VTABS = 8'h42;
   localparam logic [7:0] SEL_PAGE_LEN = 8'h43;
   localparam logic [7:0] SEL_HTABS = 8'h44;
   localparam logic [7:0] SEL_EMPH_ON = 8'h45;
   localparam logic [7:0] SEL_EMPH_OFF = 8'h46;
   localparam logic [7:0] SEL_DSTRIKE_ON = 8'h47;
   localparam logic [7:0] SEL_DSTRIKE_OFF = 8'h48;
   localparam logic [7:0] SEL_ONE_FEED = 8'h4A;
   localparam logic [7:0] SEL_GRAPHICS = 8'h4B;
   // Line pitch is kept in 1/216 inch units
   localparam logic [8:0] PITCH_SIXTH = 9'h024;
   localparam logic [8:0] PITCH_EIGHTH = 9'h01B;
   localparam logic [8:0] PITCH_7_72 = 9'h015;
   localparam logic [8:0] PITCH_72_SCALE = 9'h003;
   localparam logic [7:0] PITCH_72_MAX = 8'h55;
   localparam logic [8:0] DSTRIKE_STEP = 9'h001;
   localparam logic [6:0] PAGE_LEN_DEFAULT = 7'h42;
   localparam logic [6:0] PAGE_LEN_MAX = 7'h7F;
   localparam int VTAB_MAX = 64;
   localparam int HTAB_MAX = 112;
   localparam logic [7:0] HTAB_COL_MAX = 8'h50;
   localparam logic [7:0] HTAB_COL_MAX_COMP = 8'h84;
   localparam logic [9:0] GFX_MAX_BYTES = 10'h1E0;
   localparam logic [9:0] TEXT_DOTS = 10'h006;
   localparam int FIFO_DEPTH = 8;
   localparam int FIFO_WIDTH = 8;
   localparam real INIT_MIN_US = 50.0;
   localparam real CLK_MHZ = 125.0;
   localparam int INIT_MIN_CYC = int'(INIT_MIN_US * CLK_MHZ);
   typedef enum logic [3:0] {
      ST_DATA = 4'b0000,
      ST_SELECT = 4'b0001,
      ST_PARAM = 4'b0011,
      ST_LIST = 4'b0010,
      ST_GFX_LO = 4'b0110,
      ST_GFX_HI = 4'b0111,
      ST_GFX_DATA = 4'b0101
   } dmp_state_t;
endpackage
`default_nettype wire

// [tb/dmp_host.sv]
// Host adapter model: strobes bytes into the parser one at a time.
// Assumes the device answers each taken byte with one accept pulse.
`default_nettype none
module dmp_host (
   input wire logic clk,
   input wire logic busy,
   input wire logic byte_accept_pulse,
   output logic [7:0] host_data,
   output logic host_strobe_n
);
   timeunit 1ns;
   timeprecision 1ps;
   int gap = 4;
   initial
   begin
      host_data = 8'h00;
      host_strobe_n = 1'b1;
   end
   task automatic send(input logic [7:0] b, output bit ok);
      int n;
      ok = 0;
      @(posedge clk);
      for (n = 0; n < 20 && busy !== 1'b0; n++)
         @(posedge clk);
      #1 host_data = b;
      host_strobe_n = 1'b0;
      for (n = 0; n < 12 && !ok; n++)
      begin
         @(posedge clk);
         ok = (byte_accept_pulse === 1'b1);
      end
      #1 host_strobe_n = 1'b1;
      host_data = ~b;
      repeat (gap) @(posedge clk);
   endtask
endmodule // dmp_host
`default_nettype wire

// [tb/dmp_monitor.sv]
// Checker: port-level properties of the print command parser.
// Assumes it is bound to dmp_parser and sees only that module's ports.
`default_nettype none
module dmp_monitor (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic select_override_switch,
   input wire logic paper_end_sensor,
   input wire logic busy,
   input wire logic byte_accept_pulse,
   input wire logic selected,
   input wire logic paper_end,
   input wire logic mode_double_width,
   input wire logic mode_emphasized,
   input wire logic mode_half_speed,
   input wire logic mode_double_strike,
   input wire logic [8:0] dstrike_step,
   input wire logic [9:0] line_dots
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_pulse;
      byte_accept_pulse ##1 !byte_accept_pulse;
   endsequence
   sequence s_took;
      $past(byte_accept_pulse);
   endsequence
   a_accept_one_cycle: assert property (byte_accept_pulse |-> s_pulse)
      else $error("accept pulse too long");
   a_wide_after_byte: assert property ($rose(mode_double_width) |-> s_took)
      else $error("double width without a byte");
   a_half_speed_emph: assert property (mode_half_speed == mode_emphasized)
      else $error("half speed differs from emphasized");
   a_dstrike_step_one: assert property (mode_double_strike |-> dstrike_step == 9'h001)
      else $error("double strike step wrong");
   a_paper_end_sensed: assert property (paper_end |-> $past(paper_end_sensor))
      else $error("paper end without sensor");
   a_override_selects: assert property (select_override_switch |-> selected)
      else $error("override set but deselected");
   a_deselect_busy: assert property (!selected |-> busy)
      else $error("deselected but not busy");
   a_dots_step: assert property ($changed(line_dots) |-> line_dots == 10'h000 ||
      line_dots == $past(line_dots) + 10'h001 || line_dots == $past(line_dots) + 10'h006)
      else $error("line dots bad step");
endmodule // dmp_monitor
bind dmp_parser dmp_monitor mon_u (.*);
`default_nettype wire

// [tb/tb_top.sv]
// Testbench: drives the parser byte by byte and checks its mode outputs.
// Assumes dmp_host as host model and dmp_monitor bound to the parser.
`default_nettype none
module tb_top;
   import dmp_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, init_n, select_input, select_override_switch, paper_end_sensor;
   logic [7:0] host_data;
   logic host_strobe_n, busy, byte_accept_pulse, selected, paper_end, mode_double_width;
   logic mode_compressed, mode_underline, mode_emphasized, mode_half_speed, mode_double_strike;
   logic mode_charset_2, home_head_pending, feed_pulse, gfx_valid;
   logic [8:0] dstrike_step, line_pitch, feed_amount, last_feed;
   logic [6:0] page_length, vtab_count, htab_count;
   logic [9:0] line_dots;
   logic [7:0] ends[3] = '{CODE_CR, CODE_LF, CODE_WIDE_OFF};
   int error_cnt = 0, compares = 0, gfx_n = 0;
   bit ok;
   dmp_parser dut_u (.clk, .rst_n, .host_data, .host_strobe_n, .init_n, .select_input,
      .select_override_switch, .paper_end_sensor, .busy, .byte_accept_pulse, .selected,
      .paper_end, .mode_double_width, .mode_compressed, .mode_underline, .mode_emphasized,
      .mode_half_speed, .mode_double_strike, .dstrike_step, .mode_charset_2, .line_pitch,
      .page_length, .home_head_pending, .vtab_count, .htab_count, .tab_stop_value(),
      .vtab_stop_write(), .htab_stop_write(), .buffer_clear(), .print_line(), .feed_pulse,
      .feed_amount, .char_valid(), .char_data(), .gfx_valid, .gfx_data(), .line_dots);
   dmp_host host_u (.clk, .busy, .byte_accept_pulse, .host_data, .host_strobe_n);
   initial
   begin
      clk = 0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk)
   begin
      if (gfx_valid === 1'b1) gfx_n++;
      if (feed_pulse === 1'b1) last_feed <= feed_amount;
   end
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tx(input logic [7:0] b);
      host_u.send(b, ok);
      #1;
   endtask
   task automatic esc(input logic [7:0] s);
      tx(CODE_ESC);
      tx(s);
   endtask
   task automatic conclude;
      if (error_cnt == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      #400000;
      error_cnt++;
      conclude;
   end
   initial
   begin
      rst_n = 0; init_n = 1; select_input = 0; select_override_switch = 1; paper_end_sensor = 1;
      repeat (8) @(posedge clk);
      #1 rst_n = 1;
      repeat (6) @(posedge clk);
      #1 chk(line_pitch, 9'h024);
      chk(page_length, 7'h42);
      chk(paper_end, 1'b1);
      tx(CODE_SEL_OFF);
      chk(selected, 1'b1);
      select_override_switch = 0;
      host_u.gap = 10;
      foreach (ends[i])
      begin
         tx(CODE_WIDE_ON);
         chk(mode_double_width, 1'b1);
         tx(ends[i]);
         chk(mode_double_width, 1'b0);
      end
      host_u.gap = 4;
      tx(CODE_COMP_ON);
      chk(mode_compressed, 1'b1);
      tx(CODE_COMP_OFF);
      chk(mode_compressed, 1'b0);
      tx(CODE_WIDE_ON); esc(SEL_EMPH_ON); esc(SEL_DSTRIKE_ON); esc(SEL_UNDERLINE); tx(8'h01);
      tx(CODE_CANCEL);
      chk(mode_double_width, 1'b0);
      chk(mode_half_speed, 1'b1);
      chk(dstrike_step, 9'h001);
      chk(mode_underline, 1'b1);
      esc(SEL_EMPH_OFF); esc(SEL_DSTRIKE_OFF); esc(SEL_UNDERLINE); tx(8'h00);
      chk({mode_emphasized, mode_double_strike, mode_underline}, 3'h0);
      esc(SEL_PITCH_8TH);
      chk(line_pitch, 9'h01B);
      esc(SEL_PITCH_APPLY);
      chk(line_pitch, 9'h024);
      esc(SEL_PITCH_7_72); esc(SEL_PITCH_72); tx(8'h18);
      chk(line_pitch, 9'h015);
      esc(SEL_PITCH_APPLY);
      chk(line_pitch, 9'h048);
      esc(SEL_PITCH_216); tx(8'hFF);
      chk(line_pitch, 9'h0FF);
      esc(SEL_ONE_FEED); tx(8'h32);
      chk({last_feed, line_pitch}, {9'h032, 9'h0FF});
      tx(CODE_VT);
      chk(last_feed, 9'h0FF);
      esc(8'h7E); tx(CODE_WIDE_ON);
      chk({mode_double_width, line_pitch}, {1'b1, 9'h0FF});
      esc(SEL_CHARSET_2);
      chk(mode_charset_2, 1'b1);
      esc(SEL_CHARSET_1); esc(SEL_PE_IGNORE);
      chk({mode_charset_2, paper_end}, 2'h0);
      esc(SEL_PE_SENSE); esc(SEL_HOME_HEAD);
      chk({paper_end, home_head_pending}, 2'h3);
      tx(CODE_LF);
      chk(home_head_pending, 1'b0);
      esc(SEL_PAGE_LEN); tx(8'h37);
      chk(page_length, 7'h37);
      esc(SEL_VTABS); tx(8'h0A); tx(8'h14);
      chk(vtab_count, 7'h00);
      tx(CODE_NUL);
      chk(vtab_count, 7'h02);
      esc(SEL_VTABS); tx(CODE_NUL);
      chk(vtab_count, 7'h00);
      esc(SEL_HTABS); tx(8'h0A); tx(8'h14); tx(8'h28); tx(CODE_NUL);
      chk(htab_count, 7'h03);
      tx(CODE_CR); gfx_n = 0;
      esc(SEL_GRAPHICS); tx(8'h03); tx(8'h00); tx(CODE_CR); tx(CODE_ESC); tx(CODE_LF); tx(8'h41);
      chk(gfx_n, 10'h003);
      chk(line_dots, 10'h009);
      init_n = 0;
      repeat (6260) @(posedge clk);
      #1 init_n = 1;
      repeat (8) @(posedge clk);
      #1 chk({line_pitch, page_length}, {9'h024, 7'h42});
      tx(CODE_SEL_OFF);
      chk({selected, busy}, 2'h1);
      host_u.send(8'h41, ok);
      chk(ok, 1'b0);
      conclude;
   end
endmodule // tb_top
`default_nettype wire
